/* design/ssc_pkg.sv */
// Constants, register map and state type of the sampling sync controller.
package ssc_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Clock and timing.
  localparam int unsigned CLK_HZ    = 100_000_000;      // Core clock rate in Hz.
  localparam real         PULSE_MS  = 1.95;             // Sync pulse width in ms.
  localparam int unsigned PULSE_CYC_DEF =
    int'($ceil(PULSE_MS * real'(CLK_HZ) / 1000.0));     // Pulse width in cycles.
  localparam int unsigned SYS_HZ    = 1;                // System-data rate in Hz.
  localparam int unsigned SYS_CYC_DEF = CLK_HZ / SYS_HZ; // System-data period.

  ////////////////////////////////////////////////////////////////////////
  // Data widths.
  localparam int MEAS_W = 16;                           // Measurement width.
  localparam int SUM_W  = 32;                           // Accumulator width.
  localparam int CNT_W  = 16;                           // Window count width.

  ////////////////////////////////////////////////////////////////////////
  // Register byte offsets.
  localparam logic [7:0] REG_CTRL   = 8'h00;            // Control.
  localparam logic [7:0] REG_INTV   = 8'h04;            // Interval in cycles.
  localparam logic [7:0] REG_BURST  = 8'h08;            // Intervals per burst.
  localparam logic [7:0] REG_STATUS = 8'h0c;            // Status, read only.
  localparam logic [7:0] REG_SAMPLE = 8'h10;            // Last sample, read only.

  // Control fields.
  localparam int CTRL_RUN   = 0;                        // Arm or start collection.
  localparam int CTRL_END   = 1;                        // 1 end, 0 mid pulses.
  localparam int CTRL_START = 2;                        // Start on trigger.
  localparam int CTRL_SAMP  = 3;                        // Sample on trigger.
  localparam int CTRL_BURST = 4;                        // Burst operation.
  localparam int CTRL_W     = 5;                        // Control width.

  // Reset values.
  localparam logic [CTRL_W-1:0] CTRL_RST  = 5'h00;
  localparam logic [31:0]       INTV_RST  = 32'h002f_af08; // 32 Hz interval.
  localparam logic [15:0]       BURST_RST = 16'h0000;

  ////////////////////////////////////////////////////////////////////////
  // Sequencer states, Gray coded along the usual path.
  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_HEADER = 3'h1,
    ST_SYSDAT = 3'h3,
    ST_WAIT   = 3'h2,
    ST_RUN    = 3'h6
  } ssc_state_type;

endpackage : ssc_pkg

/* design/ssc_top.sv */
// Sampling sync controller with an AHB-Lite register slave.
`timescale 1ns/1ps
// What this block does
// RULE1: Each output pulse is high 1.95 ms.
// RULE2: Mid scheme pulses at interval midpoint.
// RULE3: End scheme pulses at interval completion.
// RULE4: One extra pulse when sampling starts.
// RULE5: Untriggered mode ignores input, software starts.
// RULE6: Trigger mode starts on input rising edge.
// RULE7: After start, further edges are ignored.
// RULE8: Per-sample triggering needs start-on-trigger enabled.
// RULE9: First edge no sample; second edge first.
// RULE10: Each sample averages since previous edge.
// RULE11: Trigger edges no faster than configured rate.
// RULE12: Start edge launches own-clock 1 Hz system data.
// RULE13: Header, one system sample, then await trigger.
// RULE14: Burst repeats header, sample, wait each burst.
// RULE15: No input filtering; any edge triggers.
// RULE16: Two-stage synchroniser, compare successive samples.
module ssc_top #(
  parameter int unsigned PULSE_CYC = ssc_pkg::PULSE_CYC_DEF, // Pulse width.
  parameter int unsigned SYS_CYC   = ssc_pkg::SYS_CYC_DEF    // 1 Hz period.
) (
  // Clock and reset.
  input  wire logic                      hclk,
  input  wire logic                      hresetn,
  // AHB-Lite slave.
  input  wire logic                      hsel,
  input  wire logic [31:0]               haddr,
  input  wire logic [1:0]                htrans,
  input  wire logic                      hwrite,
  input  wire logic [2:0]                hsize,
  input  wire logic [31:0]               hwdata,
  input  wire logic                      hready,
  output logic      [31:0]               hrdata,
  output logic                           hreadyout,
  output logic                           hresp,
  // Sync pins.
  input  wire logic                      sync_in,
  output logic                           trigger_pulse_output,
  // Measurement stream.
  input  wire logic                      meas_valid,
  input  wire logic [ssc_pkg::MEAS_W-1:0] meas_data,
  // Data product strobes.
  output logic                           sample_valid,
  output logic      [ssc_pkg::MEAS_W-1:0] sample_data,
  output logic                           header_strobe,
  output logic                           sysdata_strobe,
  output logic                           collecting
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations.
  ssc_pkg::ssc_state_type      state_ff;      // Sequencer state.
  ssc_pkg::ssc_state_type      nxt_state;     // Next state.
  logic [ssc_pkg::CTRL_W-1:0]  ctrl_ff;       // Control register.
  logic [31:0]                 intv_ff;       // Interval length.
  logic [15:0]                 burst_ff;      // Intervals per burst.
  logic                        wr_pend_ff;    // Write data phase pending.
  logic [7:0]                  wr_addr_ff;    // Latched write offset.
  logic [31:0]                 hrdata_ff;     // Read data.
  logic                        sync_s1_ff;    // Synchroniser stage one.
  logic                        sync_s2_ff;    // Synchroniser stage two.
  logic                        sync_s3_ff;    // Previous synced sample.
  logic [31:0]                 intv_cnt_ff;   // Position in interval.
  logic [31:0]                 pulse_cnt_ff;  // Pulse cycles left.
  logic [31:0]                 nxt_pulse;     // Next pulse count.
  logic                        trig_ff;       // Registered pulse pin.
  logic [31:0]                 sys_cnt_ff;    // System-data timer.
  logic [15:0]                 burst_cnt_ff;  // Intervals in burst.
  logic [ssc_pkg::SUM_W-1:0]   acc_sum_ff;    // Window sum.
  logic [ssc_pkg::CNT_W-1:0]   acc_cnt_ff;    // Window sample count.
  logic                        smp_vld_ff;    // Sample strobe.
  logic [ssc_pkg::MEAS_W-1:0]  smp_data_ff;   // Sample value.
  logic                        hdr_ff;        // Header strobe.
  logic                        sys_ff;        // System-data strobe.

  ////////////////////////////////////////////////////////////////////////
  // Bus decode and register selects.
  wire        take    = hsel & hready & htrans[1];
  wire        wr_ctrl = wr_pend_ff & (wr_addr_ff == ssc_pkg::REG_CTRL);
  wire        wr_intv = wr_pend_ff & (wr_addr_ff == ssc_pkg::REG_INTV);
  wire        wr_brst = wr_pend_ff & (wr_addr_ff == ssc_pkg::REG_BURST);
  wire [7:0]  ra      = haddr[7:0];
  wire [31:0] status  = {12'h000, burst_cnt_ff, state_ff, collecting};
  // Unmapped offsets read as zero.
  wire [31:0] rd_mux  =
    (ra == ssc_pkg::REG_CTRL)   ? {27'h0000000, ctrl_ff} :
    (ra == ssc_pkg::REG_INTV)   ? intv_ff :
    (ra == ssc_pkg::REG_BURST)  ? {16'h0000, burst_ff} :
    (ra == ssc_pkg::REG_STATUS) ? status :
    (ra == ssc_pkg::REG_SAMPLE) ? {16'h0000, smp_data_ff} : 32'h0000_0000;

  // Control fields.
  wire run       = ctrl_ff[ssc_pkg::CTRL_RUN];
  wire end_sch   = ctrl_ff[ssc_pkg::CTRL_END];
  wire start_trg = ctrl_ff[ssc_pkg::CTRL_START];
  // Per-sample only counts with start-on-trigger set. [RULE8]
  wire per       = ctrl_ff[ssc_pkg::CTRL_SAMP] & start_trg;
  wire burst_en  = ctrl_ff[ssc_pkg::CTRL_BURST];

  // Zero wait states and always OKAY.
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_ff;

  ////////////////////////////////////////////////////////////////////////
  // Address phase capture; the write lands one edge later.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      hrdata_ff  <= 32'h0000_0000;
    end else begin
      wr_pend_ff <= take & hwrite;
      if (take) begin
        wr_addr_ff <= ra;
      end
      // Read data is sampled at address phase so it stands all data phase.
      if (take & ~hwrite) begin
        hrdata_ff <= rd_mux;
      end
    end
  end

  // Software registers.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_ff  <= ssc_pkg::CTRL_RST;
      intv_ff  <= ssc_pkg::INTV_RST;
      burst_ff <= ssc_pkg::BURST_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_ff <= hwdata[ssc_pkg::CTRL_W-1:0];
      end
      if (wr_intv) begin
        intv_ff <= hwdata;
      end
      if (wr_brst) begin
        burst_ff <= hwdata[15:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sync input: plain two-stage synchroniser, no glitch filter, so a
  // noise spike that survives the pins is a real trigger. [RULE15] [RULE16]
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync_s1_ff <= 1'b0;
      sync_s2_ff <= 1'b0;
      sync_s3_ff <= 1'b0;
    end else begin
      sync_s1_ff <= sync_in;
      sync_s2_ff <= sync_s1_ff;
      sync_s3_ff <= sync_s2_ff;
    end
  end

  wire edge_in  = sync_s2_ff & ~sync_s3_ff;     // Rising edge. [RULE16]

  ////////////////////////////////////////////////////////////////////////
  // Interval timing terms.
  wire in_run   = (state_ff == ssc_pkg::ST_RUN);
  wire intv_end = in_run & (intv_cnt_ff == intv_ff - 32'd1);
  wire intv_mid = in_run & (intv_cnt_ff == {1'b0, intv_ff[31:1]});
  wire burst_done = burst_en & intv_end & (burst_ff != 16'h0000) &
                    (burst_cnt_ff == burst_ff - 16'd1);

  ////////////////////////////////////////////////////////////////////////
  // Sequencer: header, one system sample, optional wait, then run.
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ssc_pkg::ST_IDLE: begin
        if (run) begin
          nxt_state = ssc_pkg::ST_HEADER;
        end
      end
      ssc_pkg::ST_HEADER: begin
        nxt_state = ssc_pkg::ST_SYSDAT;            // [RULE13]
      end
      ssc_pkg::ST_SYSDAT: begin
        // Untriggered mode never looks at the pin. [RULE5] [RULE13]
        nxt_state = start_trg ? ssc_pkg::ST_WAIT : ssc_pkg::ST_RUN;
      end
      ssc_pkg::ST_WAIT: begin
        if (edge_in) begin
          nxt_state = ssc_pkg::ST_RUN;             // [RULE6]
        end
      end
      ssc_pkg::ST_RUN: begin
        // Each new burst goes through the whole start-up again. [RULE14]
        if (burst_done) begin
          nxt_state = ssc_pkg::ST_HEADER;
        end
      end
      default: begin
        nxt_state = ssc_pkg::ST_IDLE;
      end
    endcase
    // Clearing the run bit aborts from any state.
    if (!run) begin
      nxt_state = ssc_pkg::ST_IDLE;
    end
  end

  wire go_run = (nxt_state == ssc_pkg::ST_RUN) & ~in_run;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= ssc_pkg::ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interval and burst counters restart with each start of sampling.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      intv_cnt_ff  <= 32'h0000_0000;
      burst_cnt_ff <= 16'h0000;
    end else if (go_run || !in_run) begin
      intv_cnt_ff  <= 32'h0000_0000;
      burst_cnt_ff <= 16'h0000;
    end else if (intv_end) begin
      intv_cnt_ff  <= 32'h0000_0000;
      burst_cnt_ff <= burst_cnt_ff + 16'd1;
    end else begin
      intv_cnt_ff  <= intv_cnt_ff + 32'd1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output pulse: the start of sampling plus one per interval at the
  // chosen point. An interval shorter than the pulse merges pulses.
  wire pulse_sched = end_sch ? intv_end : intv_mid;  // [RULE2] [RULE3]
  wire fire        = go_run | pulse_sched;           // [RULE4]

  // Each pulse reloads the full width. [RULE1]
  assign nxt_pulse = fire ? PULSE_CYC :
                     (pulse_cnt_ff != 32'd0) ? pulse_cnt_ff - 32'd1 : 32'd0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pulse_cnt_ff <= 32'h0000_0000;
      trig_ff      <= 1'b0;
    end else begin
      pulse_cnt_ff <= nxt_pulse;
      trig_ff      <= (nxt_pulse != 32'd0);     // [RULE1]
    end
  end

  assign trigger_pulse_output = trig_ff;

  ////////////////////////////////////////////////////////////////////////
  // System data runs from the local timer, never from the pin. [RULE12]
  wire sys_tick = in_run & (sys_cnt_ff == SYS_CYC - 1);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sys_cnt_ff <= 32'h0000_0000;
    end else if (go_run || !in_run || sys_tick) begin
      sys_cnt_ff <= 32'h0000_0000;                // [RULE12]
    end else begin
      sys_cnt_ff <= sys_cnt_ff + 32'd1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sample points: pin edges in per-sample mode, else interval ends.
  // Outside per-sample mode running ignores the pin entirely. [RULE7]
  // The source must not outpace the interval. [RULE11]
  wire sample_pt = in_run & (per ? edge_in : intv_end);  // [RULE9]
  wire [ssc_pkg::SUM_W-1:0] div_w =
    acc_sum_ff / {{(ssc_pkg::SUM_W-ssc_pkg::CNT_W){1'b0}}, acc_cnt_ff};
  // An empty window reports zero rather than dividing by zero.
  wire [ssc_pkg::MEAS_W-1:0] avg_w = (acc_cnt_ff == 16'h0000) ?
    16'h0000 : div_w[ssc_pkg::MEAS_W-1:0];             // [RULE10]
  wire [ssc_pkg::SUM_W-1:0] meas_ext =
    {{(ssc_pkg::SUM_W-ssc_pkg::MEAS_W){1'b0}}, meas_data};

  // The start edge opens the first window and emits nothing. [RULE9]
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_sum_ff <= 32'h0000_0000;
      acc_cnt_ff <= 16'h0000;
    end else if (go_run) begin
      acc_sum_ff <= 32'h0000_0000;
      acc_cnt_ff <= 16'h0000;
    end else if (sample_pt) begin
      // A measurement in the closing cycle opens the next window. [RULE10]
      acc_sum_ff <= meas_valid ? meas_ext : 32'h0000_0000;
      acc_cnt_ff <= {15'h0000, meas_valid};
    end else if (in_run && meas_valid) begin
      acc_sum_ff <= acc_sum_ff + meas_ext;
      acc_cnt_ff <= acc_cnt_ff + 16'd1;
    end
  end

  // Registered data products.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      smp_vld_ff  <= 1'b0;
      smp_data_ff <= 16'h0000;
      hdr_ff      <= 1'b0;
      sys_ff      <= 1'b0;
    end else begin
      smp_vld_ff <= sample_pt;
      if (sample_pt) begin
        smp_data_ff <= avg_w;
      end
      hdr_ff <= (state_ff == ssc_pkg::ST_HEADER);   // [RULE13]
      sys_ff <= (state_ff == ssc_pkg::ST_SYSDAT) | sys_tick; // [RULE13]
    end
  end

  assign sample_valid   = smp_vld_ff;
  assign sample_data    = smp_data_ff;
  assign header_strobe  = hdr_ff;
  assign sysdata_strobe = sys_ff;
  assign collecting     = in_run;

  ////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_PULSE_LOAD: assert property (fire |=> pulse_cnt_ff == PULSE_CYC) // [RULE1]
    else $error("pulse width not loaded");
  AST_PULSE_END: assert property ($fell(trig_ff) |-> $past(pulse_cnt_ff) == 32'd1) // [RULE1]
    else $error("pulse ended early");
  AST_MID: assert property (intv_mid && !end_sch |=> trig_ff ##0 pulse_cnt_ff == PULSE_CYC) // [RULE2]
    else $error("no mid pulse");
  AST_END: assert property (intv_end && end_sch |=> trig_ff ##0 pulse_cnt_ff == PULSE_CYC) // [RULE3]
    else $error("no end pulse");
  AST_START: assert property (go_run |=> trig_ff && collecting) // [RULE4]
    else $error("no start pulse");
  AST_NOSYNC: assert property (state_ff == ssc_pkg::ST_SYSDAT && !start_trg && run |=> collecting) // [RULE5]
    else $error("untriggered start waited");
  AST_TRIG_START: assert property (state_ff == ssc_pkg::ST_WAIT && edge_in && run |=> collecting) // [RULE6]
    else $error("edge did not start");
  AST_IGNORE: assert property (in_run && !per && edge_in && !intv_end |=> !sample_valid) // [RULE7]
    else $error("edge sampled when ignored");
  AST_PER_NEEDS_START: assert property (in_run && !start_trg && edge_in && !intv_end |=> !sample_valid) // [RULE8]
    else $error("per-sample without start");
  AST_FIRST_EDGE: assert property (go_run |=> !sample_valid) // [RULE9]
    else $error("sample on start edge");
  AST_AVG: assert property (in_run && per && edge_in |=> sample_valid && sample_data == $past(avg_w)) // [RULE10]
    else $error("bad per-edge average");
  AST_SYS_TIMER: assert property (go_run |=> sys_cnt_ff == 32'd0 ##1 !sysdata_strobe) // [RULE12]
    else $error("system data not restarted");
  AST_SEQ: assert property (state_ff == ssc_pkg::ST_HEADER && run |=> header_strobe ##1 sysdata_strobe) // [RULE13]
    else $error("bad start-up order");
  AST_BURST: assert property (burst_done && run |=> state_ff == ssc_pkg::ST_HEADER) // [RULE14]
    else $error("burst did not restart");

  COV_PER: cover property (in_run && per && edge_in ##1 sample_valid);
  COV_MID: cover property (intv_mid && !end_sch);
  COV_BURST: cover property (burst_done && run);

endmodule // ssc_top

/* bench/ssc_peer.sv */
// Model of a neighbouring instrument: a trigger source and a receiver of sync pulses.
`timescale 1ns/1ps
module ssc_peer #(
  parameter int PW = 20, // Width in cycles that every received pulse must have.
  parameter int HI = 2   // Width in cycles of the trigger pulse that we send.
) (
  // Clock and reset.
  input  wire logic hclk,
  input  wire logic hresetn,
  // Trigger request from the bench and the line that we drive.
  input  wire logic send,
  output logic      sync_in,
  // Pulse line from the device and our tallies of it.
  input  wire logic trigger_pulse_output,
  output int        pulses,
  output int        bad_width
);
  int   hi_left; // Cycles left of our own trigger pulse.
  int   width;   // Width so far of the pulse being received.
  logic prev;    // Pulse line as seen one edge earlier.

  ////////////////////////////////////////////////////////////////////////
  // The line has a pull-down, so it rests low between triggers.
  // Our pulse is kept short on purpose: nothing may filter it away.
  // The bench only asks for a trigger once per configured interval.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hi_left <= 0;
      sync_in <= 1'b0;
    end else if (send) begin
      hi_left <= HI - 1;
      sync_in <= 1'b1;
    end else begin
      hi_left <= (hi_left > 0) ? hi_left - 1 : 0;
      sync_in <= (hi_left > 0);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Count received pulses and flag any whose width is not exactly PW.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev      <= 1'b0;
      width     <= 0;
      pulses    <= 0;
      bad_width <= 0;
    end else begin
      prev <= trigger_pulse_output;
      if (trigger_pulse_output === 1'b1) begin
        width <= width + 1;
        if (prev !== 1'b1) pulses <= pulses + 1;
      end else begin
        width <= 0;
        if (prev === 1'b1 && width != PW) bad_width <= bad_width + 1;
      end
    end
  end
endmodule // ssc_peer

/* bench/sampling_sync_control_tb.sv */
// Self-checking testbench of the sampling sync controller.
`timescale 1ns/1ps
module sampling_sync_control_tb;
  localparam int PW = 20;  // Short pulse width keeps the run brief.
  localparam int SC = 200; // Short system-data period.
  localparam int IV = 50;  // Interval written to the device.

  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, send, meas_valid;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        sync_in, tpo, sample_valid, header_strobe, sysdata_strobe, collecting;
  logic [15:0] meas_data, sample_data;
  int          failures, check_count, n_hdr, n_sys, n_smp, cyc, hdr_at, sys_at;
  int          pulses, bad_width, p0, s0, y0, h0;

  ssc_top #(.PULSE_CYC(PW), .SYS_CYC(SC)) uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .sync_in(sync_in), .trigger_pulse_output(tpo),
    .meas_valid(meas_valid), .meas_data(meas_data), .sample_valid(sample_valid),
    .sample_data(sample_data), .header_strobe(header_strobe), .sysdata_strobe(sysdata_strobe),
    .collecting(collecting));

  ssc_peer #(.PW(PW), .HI(2)) peer (
    .hclk(hclk), .hresetn(hresetn), .send(send), .sync_in(sync_in),
    .trigger_pulse_output(tpo), .pulses(pulses), .bad_width(bad_width));

  ////////////////////////////////////////////////////////////////////////
  // Clock of 100 MHz.
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  // Tally the one-cycle strobes and note when the last header and system sample came.
  always @(posedge hclk) begin
    cyc = cyc + 1;
    if (header_strobe === 1'b1) begin n_hdr = n_hdr + 1; hdr_at = cyc; end
    if (sysdata_strobe === 1'b1) begin n_sys = n_sys + 1; sys_at = cyc; end
    if (sample_valid === 1'b1) n_smp = n_smp + 1;
  end

  ////////////////////////////////////////////////////////////////////////
  // One AHB-Lite single transfer; the answer is awaited, never assumed.
  task automatic ahb(input logic w, input logic [31:0] a, d, output logic [31:0] r);
    hsel <= 1'b1; haddr <= a; htrans <= 2'b10; hwrite <= w; hsize <= 3'b010;
    @(posedge hclk); while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
    @(posedge hclk); while (hreadyout !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, d); ahb(1'b1, a, d, rd); endtask
  task automatic chk(input logic [31:0] g, e, input string m);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("ERROR at %0t: %s got %h expected %h", $time, m, g, e);
    end
  endtask
  task automatic rdc(input logic [31:0] a, e, input string m); ahb(1'b0, a, 32'h0, rd); chk(rd, e, m); endtask
  task automatic tick(input int n); repeat (n) @(posedge hclk); endtask
  task automatic fire(); send <= 1'b1; @(posedge hclk); send <= 1'b0; endtask
  task automatic feed(input logic [15:0] v);
    meas_valid <= 1'b1; meas_data <= v; @(posedge hclk); meas_valid <= 1'b0; tick(3);
  endtask
  task automatic wait_run(); while (collecting !== 1'b1) @(posedge hclk); endtask
  task automatic stop(); wr(32'(ssc_pkg::REG_CTRL), 32'h0); tick(3); chk(collecting, 1'b0, "stop"); endtask

  // Run one schedule for five intervals and check pulses, samples and system data.
  task automatic sched(input logic [31:0] ctl, input string name);
    p0 = pulses; s0 = n_smp; y0 = n_sys; h0 = n_hdr;
    wr(32'(ssc_pkg::REG_CTRL), ctl);
    tick(30);
    chk(n_hdr - h0, 1, "header");
    chk(sys_at, hdr_at + 1, "header before system data");
    chk(collecting, !ctl[2], "waits for trigger");
    if (ctl[2]) fire();
    wait_run();
    // Further edges inside the run must change nothing.
    // Edges inside any run outside per-sample mode must change nothing, untriggered runs included.
    repeat (4) begin tick(60); fire(); end
    // An untriggered run began during the first wait, so its window closes sooner.
    tick(ctl[2] ? 16 : 0);
    chk(pulses - p0, 6, "start plus periodic pulses");
    chk(bad_width, 0, "pulse width");
    chk(n_smp - s0, 5, "interval samples");
    chk(n_sys - y0, 2, "system data rate");
    stop();
    $display("test %s done", name);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Closing verdict, shared by the main sequence and the watchdog.
  task automatic final_report();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // A hang is cut short well after the tests should have ended.
  initial begin
    #200000;
    failures++;
    final_report();
  end

  ////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'b00; hwrite = 1'b0; hsize = 3'b010;
    hwdata = 32'h0; send = 1'b0; meas_valid = 1'b0; meas_data = 16'h0;
    failures = 0; check_count = 0; n_hdr = 0; n_sys = 0; n_smp = 0; cyc = 0; hdr_at = 0; sys_at = 0;
    tick(2);
    hresetn <= 1'b1;
    @(posedge hclk);
    // Reset values, a read-only place and an unmapped word.
    rdc(32'(ssc_pkg::REG_CTRL), 32'h0, "ctrl reset");
    rdc(32'(ssc_pkg::REG_INTV), ssc_pkg::INTV_RST, "interval reset");
    rdc(32'(ssc_pkg::REG_BURST), 32'h0, "burst reset");
    wr(32'(ssc_pkg::REG_STATUS), 32'hffff_ffff);
    rdc(32'(ssc_pkg::REG_STATUS), 32'h0, "status read only");
    rdc(32'h0000_0014, 32'h0, "unmapped");
    chk(hresp, 1'b0, "okay response");
    wr(32'(ssc_pkg::REG_INTV), IV);
    rdc(32'(ssc_pkg::REG_INTV), IV, "interval write");
    // Idle device ignores the trigger line entirely.
    fire(); tick(10);
    chk(collecting, 1'b0, "idle ignores trigger");
    $display("test registers done");
    sched(32'h0000_0009, "mid untriggered");
    sched(32'h0000_0007, "end start-on-trigger");
    // Per-sample triggering: first edge opens the window only.
    wr(32'(ssc_pkg::REG_CTRL), 32'h0000_000d); tick(30);
    s0 = n_smp;
    fire(); tick(10);
    chk(collecting, 1'b1, "first edge starts");
    feed(16'h000a); feed(16'h0014); feed(16'h001e); tick(38);
    chk(n_smp - s0, 0, "no sample at first edge");
    fire(); tick(5);
    chk(n_smp - s0, 1, "sample at second edge");
    chk({16'h0, sample_data}, 32'h14, "average of window");
    feed(16'h0007); feed(16'h0008); tick(46);
    fire(); tick(5);
    chk({16'h0, sample_data}, 32'h7, "floor average");
    rdc(32'(ssc_pkg::REG_SAMPLE), 32'h7, "sample register");
    stop();
    $display("test per-sample done");
    // Burst of two intervals: header, one system sample and a new wait each time.
    wr(32'(ssc_pkg::REG_BURST), 32'h2);
    wr(32'(ssc_pkg::REG_CTRL), 32'h0000_0015); tick(30);
    h0 = n_hdr;
    fire(); wait_run(); tick(130);
    chk(n_hdr - h0, 1, "header again per burst");
    chk(sys_at, hdr_at + 1, "system data after burst header");
    chk(collecting, 1'b0, "waits again");
    rdc(32'(ssc_pkg::REG_STATUS), 32'h4, "status shows wait state");
    fire(); tick(10);
    chk(collecting, 1'b1, "next burst starts");
    stop();
    $display("test burst done");
    final_report();
  end
endmodule // sampling_sync_control_tb
